// >>> hw/dtbb_pkg.sv
// Shared constants for the trace buffer and breakpoint block
package dtbb_pkg;
  localparam int unsigned DEPTH = 64;
  localparam int unsigned LINE_AW = 6;
  localparam int unsigned CNT_W = 7;
  localparam int unsigned PC_W = 18;
  localparam int unsigned ROW_W = 20;
  localparam int unsigned OFS_W = 6;
  localparam int unsigned CMP_N = 3;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // Register byte addresses
  localparam logic [7:0] ADDR_TRACE_HI = 8'h00;
  localparam logic [7:0] ADDR_TRACE_LO = 8'h01;
  localparam logic [7:0] ADDR_CTRL = 8'h02;
  localparam logic [7:0] ADDR_COUNT = 8'h03;
  localparam logic [7:0] ADDR_TAGCFG = 8'h04;

  // Control register bits and the tag configuration range field
  localparam int unsigned CTRL_ARM = 0;
  localparam int unsigned CTRL_SOFTWARE_TRIGGER = 1;
  localparam int unsigned CTRL_ALIGN = 2;
  localparam int unsigned CTRL_IBRK = 3;
  localparam int unsigned CTRL_BRKEN = 4;
  localparam int unsigned CTRL_TSRC = 5;
  localparam int unsigned TAGCFG_RANGE_LSB = 8;

  // Row format codes
  localparam logic [1:0] FMT_BASE = 2'h0;
  localparam logic [1:0] FMT_ONE = 2'h1;
  localparam logic [1:0] FMT_TWO = 2'h2;
  localparam logic [1:0] FMT_THREE = 2'h3;

  localparam logic [6:0] COUNT_FULL = 7'h40;
  localparam logic [5:0] LINE_LAST = 6'h3F;
  localparam logic [5:0] LINE_FIRST = 6'h00;
endpackage

// >>> hw/dtbb_mem.sv
// Trace line storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module dtbb_mem #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned AW = 6
) (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  // Contents are never cleared so they survive system reset
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// >>> hw/dtbb_tag.sv
// One comparator channel: immediate match or opcode tagging
`timescale 1ns/1ps
`default_nettype none
module dtbb_tag #(
  parameter int unsigned PCW = 18
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_match,
  input wire logic [PCW-1:0] i_match_pc,
  input wire logic i_quals_ok,
  input wire logic i_tag_en,
  input wire logic i_range,
  input wire logic i_head_valid,
  input wire logic [PCW-1:0] i_head_pc,
  input wire logic i_bdm_active,
  output logic o_event
);
  logic tag_q;
  logic [PCW-1:0] tag_pc_q;
  logic range_q;
  wire immediate_hit;
  wire pc_same;
  wire tag_hit;

  assign immediate_hit = i_match & ~i_tag_en & i_quals_ok & ~i_bdm_active;
  // Qualifiers unused when tagging
  assign pc_same = range_q ? (i_head_pc[PCW-1:1] == tag_pc_q[PCW-1:1])
                           : (i_head_pc == tag_pc_q);
  assign tag_hit = tag_q & i_head_valid & pc_same & ~i_bdm_active;
  assign o_event = immediate_hit | tag_hit;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_bdm_active) begin
      tag_q <= 1'b0;
      tag_pc_q <= '0;
      range_q <= 1'b0;
    end else if (i_match && i_tag_en) begin
      tag_q <= 1'b1;
      tag_pc_q <= i_match_pc;
      range_q <= i_range;
    end else if (tag_hit) begin
      tag_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> hw/dtbb_top.sv
// Compressed PC trace buffer with readout port and breakpoint control
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dtbb_top (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_word,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  input wire logic i_secured,
  input wire logic i_background_debug_mode,
  input wire logic i_head_valid,
  input wire logic [17:0] i_head_pc,
  input wire logic [2:0] i_cmp_match,
  input wire logic [17:0] i_cmp_match_pc,
  input wire logic [2:0] i_cmp_quals_ok,
  output logic o_break_req,
  output logic o_armed,
  output logic o_tracing
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PRE,
    ST_WAIT,
    ST_POST
  } dtbb_state_t;

  function automatic logic [5:0] dtbb_next_line(input logic [5:0] line);
    dtbb_next_line = (line == dtbb_pkg::LINE_LAST) ? dtbb_pkg::LINE_FIRST : line + 6'h01;
  endfunction

  dtbb_state_t state_q;
  dtbb_state_t state_d;
  logic software_trigger_q;
  logic trigger_alignment_q;
  logic immediate_break_q;
  logic break_enable_q;
  logic trace_source_select_q;
  logic [2:0] tag_en_q;
  logic [2:0] range_q;
  logic unlocked_q;
  logic break_q;
  logic [15:0] rdata_q;
  // Kept through system reset
  logic [6:0] valid_line_count_q;
  logic buffer_wrapped_flag_q;
  logic [5:0] wr_line_q;
  logic [5:0] rd_line_q;
  logic rd_half_q;
  logic have_base_q;
  logic [11:0] base_q;
  logic [1:0] slot_q;
  logic [5:0] f0_q;
  logic [5:0] f1_q;
  logic [5:0] rd_line_d;
  logic rd_half_d;
  logic [19:0] row_d;

  wire [2:0] cmp_event;
  wire [19:0] mem_q;
  wire wr_ctrl;
  wire wr_tagcfg;
  wire wr_port_word;
  wire wr_port_high;
  wire rd_port_word;
  wire arm_write;
  wire disarm_write;
  wire sw_software_trigger_write;
  wire trigger;
  wire tracing;
  wire need_base;
  wire new_line;
  wire [5:0] line_sel;
  wire [5:0] offset;
  wire stop_full;
  wire trace_fire;
  wire end_session;
  wire break_now;
  wire read_ok;
  wire read_adv;
  wire [5:0] oldest_line;
  wire [6:0] count_inc;

  // Register decode
  assign wr_ctrl = i_reg_wr & (i_reg_addr == dtbb_pkg::ADDR_CTRL);
  assign wr_tagcfg = i_reg_wr & (i_reg_addr == dtbb_pkg::ADDR_TAGCFG);
  assign wr_port_word = i_reg_wr & i_reg_word & (i_reg_addr == dtbb_pkg::ADDR_TRACE_HI);
  assign wr_port_high = i_reg_wr & (i_reg_addr == dtbb_pkg::ADDR_TRACE_HI);
  assign rd_port_word = i_reg_rd & i_reg_word & (i_reg_addr == dtbb_pkg::ADDR_TRACE_HI);
  assign arm_write = wr_ctrl & i_reg_wdata[dtbb_pkg::CTRL_ARM];
  assign disarm_write = wr_ctrl & ~i_reg_wdata[dtbb_pkg::CTRL_ARM];
  assign sw_software_trigger_write = wr_ctrl & i_reg_wdata[dtbb_pkg::CTRL_SOFTWARE_TRIGGER];

  // Comparator channels
  genvar gi;
  generate
    for (gi = 0; gi < dtbb_pkg::CMP_N; gi++) begin : g_cmp
      dtbb_tag #(
        .PCW(dtbb_pkg::PC_W)
      ) u_tag (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_match(i_cmp_match[gi]),
        .i_match_pc(i_cmp_match_pc),
        .i_quals_ok(i_cmp_quals_ok[gi]),
        .i_tag_en(tag_en_q[gi]),
        .i_range(range_q[gi]),
        .i_head_valid(i_head_valid),
        .i_head_pc(i_head_pc),
        .i_bdm_active(i_background_debug_mode),
        .o_event(cmp_event[gi])
      );
    end
  endgenerate

  // Trigger only counts while waiting for it
  assign trigger = ((|cmp_event) | software_trigger_q) & ((state_q == ST_PRE) | (state_q == ST_WAIT));
  assign tracing = (state_q == ST_PRE) | (state_q == ST_POST);

  // Compression
  assign offset = i_head_pc[5:0];
  assign need_base = ~have_base_q | (i_head_pc[17:6] != base_q)
                   | ((slot_q == 2'h0) & (dtbb_next_line(wr_line_q) == dtbb_pkg::LINE_FIRST));
  assign new_line = need_base | (slot_q == 2'h0);
  assign line_sel = new_line ? dtbb_next_line(wr_line_q) : wr_line_q;
  // Only a real opcode needing a fresh line ends a begin aligned session
  assign stop_full = (state_q == ST_POST) & new_line & i_head_valid
                   & (valid_line_count_q == dtbb_pkg::COUNT_FULL);
  // End aligned trigger halts before the opcode is stored
  assign trace_fire = tracing & i_head_valid & ~stop_full & ~((state_q == ST_PRE) & trigger);
  assign count_inc = (valid_line_count_q == dtbb_pkg::COUNT_FULL) ? valid_line_count_q
                   : valid_line_count_q + 7'h01;

  always_comb begin
    if (need_base) begin
      row_d = {dtbb_pkg::FMT_BASE, i_head_pc};
    end else if (slot_q == 2'h0) begin
      row_d = {dtbb_pkg::FMT_ONE, 12'h000, offset};
    end else if (slot_q == 2'h1) begin
      row_d = {dtbb_pkg::FMT_TWO, 6'h00, offset, f0_q};
    end else begin
      row_d = {dtbb_pkg::FMT_THREE, offset, f1_q, f0_q};
    end
  end

  // Session end and break request
  assign end_session = (trigger & ((state_q == ST_PRE) | immediate_break_q
                                   | ~trace_source_select_q))
                     | stop_full;
  assign break_now = end_session & break_enable_q;

  always_comb begin
    state_d = state_q;
    if (arm_write) begin
      // Source select taken from the same write that arms
      if (i_reg_wdata[dtbb_pkg::CTRL_TSRC] && !i_reg_wdata[dtbb_pkg::CTRL_ALIGN]) begin
        state_d = ST_PRE;
      end else begin
        state_d = ST_WAIT;
      end
    end else if (disarm_write || end_session) begin
      state_d = ST_IDLE;
    end else if ((state_q == ST_WAIT) && trigger) begin
      state_d = ST_POST;
    end
  end

  // Readout path
  assign oldest_line = buffer_wrapped_flag_q ? dtbb_next_line(wr_line_q)
                                             : dtbb_pkg::LINE_FIRST;
  assign read_ok = (state_q == ST_IDLE) & unlocked_q & trace_source_select_q & ~i_secured;
  assign read_adv = rd_port_word & read_ok;

  always_comb begin
    rd_line_d = rd_line_q;
    rd_half_d = rd_half_q;
    if ((wr_port_word && state_q == ST_IDLE) || wr_port_high) begin
      rd_line_d = oldest_line;
      rd_half_d = 1'b0;
    end else if (read_adv) begin
      rd_half_d = ~rd_half_q;
      if (rd_half_q) begin
        rd_line_d = dtbb_next_line(rd_line_q);
      end
    end
  end

  dtbb_mem #(
    .WIDTH(dtbb_pkg::ROW_W),
    .AW(dtbb_pkg::LINE_AW)
  ) u_mem (
    .i_core_clk(i_core_clk),
    .i_we(trace_fire),
    .i_waddr(line_sel),
    .i_wdata(row_d),
    .i_raddr(rd_line_d),
    .o_rdata(mem_q)
  );

  // Control registers
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      trigger_alignment_q <= 1'b0;
      immediate_break_q <= 1'b0;
      break_enable_q <= 1'b0;
      trace_source_select_q <= 1'b0;
      tag_en_q <= 3'h0;
      range_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (wr_ctrl) begin
        trigger_alignment_q <= i_reg_wdata[dtbb_pkg::CTRL_ALIGN];
        immediate_break_q <= i_reg_wdata[dtbb_pkg::CTRL_IBRK];
        break_enable_q <= i_reg_wdata[dtbb_pkg::CTRL_BRKEN];
        trace_source_select_q <= i_reg_wdata[dtbb_pkg::CTRL_TSRC];
      end
      if (wr_tagcfg) begin
        tag_en_q <= i_reg_wdata[2:0];
        range_q <= i_reg_wdata[dtbb_pkg::TAGCFG_RANGE_LSB +: 3];
      end
    end
  end

  // Pending software trigger, new write wins over consume
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      software_trigger_q <= 1'b0;
    end else if (sw_software_trigger_write) begin
      software_trigger_q <= 1'b1;
    end else if (trigger || state_q == ST_IDLE) begin
      software_trigger_q <= 1'b0;
    end
  end

  // Lock and break pulse
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      unlocked_q <= 1'b0;
      break_q <= 1'b0;
    end else begin
      break_q <= break_now;
      if (arm_write) begin
        unlocked_q <= 1'b0;
      end else if (wr_port_word && state_q == ST_IDLE) begin
        unlocked_q <= 1'b1;
      end
    end
  end

  // Trace write state; not reset so a session survives system reset
  always_ff @(posedge i_core_clk) begin
    if (arm_write) begin
      valid_line_count_q <= 7'h00;
      buffer_wrapped_flag_q <= 1'b0;
      wr_line_q <= dtbb_pkg::LINE_LAST;
      have_base_q <= 1'b0;
      slot_q <= 2'h0;
    end else if (trace_fire) begin
      if (new_line) begin
        wr_line_q <= line_sel;
        valid_line_count_q <= count_inc;
        if (valid_line_count_q == dtbb_pkg::COUNT_FULL) begin
          buffer_wrapped_flag_q <= 1'b1;
        end
      end
      if (need_base) begin
        have_base_q <= 1'b1;
        base_q <= i_head_pc[17:6];
        slot_q <= 2'h0;
      end else if (slot_q == 2'h0) begin
        f0_q <= offset;
        slot_q <= 2'h1;
      end else if (slot_q == 2'h1) begin
        f1_q <= offset;
        slot_q <= 2'h2;
      end else begin
        slot_q <= 2'h0;
      end
    end
  end

  // Read pointer is loaded on unlock and on any write to the trace port high address
  always_ff @(posedge i_core_clk) begin
    rd_line_q <= rd_line_d;
    rd_half_q <= rd_half_d;
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 16'h0000;
    end else if (!i_reg_rd) begin
      rdata_q <= 16'h0000;
    end else if (rd_port_word) begin
      if (!read_ok) begin
        rdata_q <= 16'h0000;
      end else if (rd_half_q) begin
        rdata_q <= {12'h000, mem_q[19:16]};
      end else begin
        rdata_q <= mem_q[15:0];
      end
    end else if (i_reg_addr == dtbb_pkg::ADDR_CTRL) begin
      rdata_q <= {10'h000, trace_source_select_q, break_enable_q, immediate_break_q,
                  trigger_alignment_q, software_trigger_q, o_armed};
    end else if (i_reg_addr == dtbb_pkg::ADDR_COUNT) begin
      rdata_q <= {8'h00, buffer_wrapped_flag_q, valid_line_count_q};
    end else if (i_reg_addr == dtbb_pkg::ADDR_TAGCFG) begin
      rdata_q <= {5'h00, range_q, 5'h00, tag_en_q};
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_break_req = break_q;
  assign o_armed = (state_q != ST_IDLE);
  assign o_tracing = tracing;
endmodule
`default_nettype wire

// >>> verif/dtbb_top_sva.sv
// Port checker for the trace buffer and breakpoint block
`timescale 1ns/1ps
`default_nettype none
module dtbb_top_sva (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_word,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  input wire logic i_secured,
  input wire logic o_break_req,
  input wire logic o_armed,
  input wire logic o_tracing
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  wire tb_rd = i_reg_rd && i_reg_addr == dtbb_pkg::ADDR_TRACE_HI;
  wire ctl_wr = i_reg_wr && i_reg_addr == dtbb_pkg::ADDR_CTRL;
  rd_idle_a:
    assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000) else $error("data outside read");
  rd_byte_a:
    assert property (tb_rd && !i_reg_word |=> o_reg_rdata == 16'h0000) else $error("byte read");
  rd_misalign_a:
    assert property (i_reg_rd && i_reg_addr == dtbb_pkg::ADDR_TRACE_LO |=> o_reg_rdata == 16'h0000)
      else $error("misaligned read");
  rd_armed_a:
    assert property (tb_rd && o_armed |=> o_reg_rdata == 16'h0000) else $error("armed read");
  rd_secured_a:
    assert property (tb_rd && i_secured |=> o_reg_rdata == 16'h0000) else $error("secured read");
  brk_pulse_a:
    assert property ($rose(o_break_req) |=> !o_break_req) else $error("break too long");
  brk_disarm_a:
    assert property (o_break_req |-> !o_armed && $past(o_armed)) else $error("break while armed");
  trace_armed_a:
    assert property (o_tracing |-> o_armed) else $error("tracing while idle");
  arm_write_a:
    assert property (ctl_wr && i_reg_wdata[0] && !i_reg_wdata[1] && !o_armed |=> o_armed)
      else $error("arm ignored");
  disarm_write_a:
    assert property (ctl_wr && !i_reg_wdata[0] |=> !o_armed && !o_tracing) else $error("disarm");
  cover property (o_break_req);
  cover property ($rose(o_tracing));
  cover property (tb_rd && i_reg_word && !o_armed ##1 o_reg_rdata != 16'h0000);
endmodule
bind dtbb_top dtbb_top_sva dtbb_top_sva_i (.i_core_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata,
  .i_reg_word, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_secured, .o_break_req, .o_armed,
  .o_tracing);
`default_nettype wire

// >>> verif/dtbb_cpu_model.sv
// Instruction queue head model feeding executed opcode addresses
`timescale 1ns/1ps
`default_nettype none
module dtbb_cpu_model (
  input wire logic i_core_clk,
  input wire logic i_run,
  input wire logic i_load,
  input wire logic [17:0] i_start_pc,
  input wire logic [17:0] i_stride,
  output logic o_head_valid,
  output logic [17:0] o_head_pc
);
  logic [17:0] pc_q;
  always_ff @(posedge i_core_clk) begin
    if (i_load) begin
      pc_q <= i_start_pc;
    end else if (i_run) begin
      pc_q <= pc_q + i_stride;
    end
  end
  // One opcode at the head per running cycle
  assign o_head_valid = i_run;
  assign o_head_pc = i_run ? pc_q : ~pc_q;
endmodule
`default_nettype wire

// >>> verif/dtbb_top_test.sv
// Self-checking bench for the trace buffer block
`timescale 1ns/1ps
`default_nettype none
module dtbb_top_test;
  localparam logic [7:0] A_HI = dtbb_pkg::ADDR_TRACE_HI;
  localparam logic [7:0] A_LO = dtbb_pkg::ADDR_TRACE_LO;
  localparam logic [7:0] A_CT = dtbb_pkg::ADDR_CTRL;
  localparam logic [7:0] A_CN = dtbb_pkg::ADDR_COUNT;
  localparam logic [7:0] A_TG = dtbb_pkg::ADDR_TAGCFG;
  logic i_core_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic [7:0] i_reg_addr = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic i_reg_word = 1'h0;
  logic i_reg_wr = 1'h0;
  logic i_reg_rd = 1'h0;
  logic i_secured = 1'h0;
  logic background_debug_mode = 1'h0;
  logic [2:0] cm = 3'h0;
  logic [17:0] mpc = 18'h00000;
  logic [2:0] qok = 3'h0;
  logic run = 1'h0;
  logic load = 1'h0;
  logic [17:0] spc = 18'h00000;
  logic [17:0] step = 18'h00002;
  wire hv;
  wire [17:0] hpc;
  wire [15:0] rdata;
  wire immediate_break;
  wire armed;
  wire tracing;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 55380;
  int n;
  int tot = 0;
  logic [19:0] rows[$];
  logic [17:0] base;
  logic [17:0] p;
  logic [17:0] q;
  logic wrapped;
  logic seen;

  dtbb_top dtbb_top_i (.i_core_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_word,
    .i_reg_wr, .i_reg_rd, .o_reg_rdata(rdata), .i_secured, .i_background_debug_mode(background_debug_mode),
    .i_head_valid(hv), .i_head_pc(hpc), .i_cmp_match(cm), .i_cmp_match_pc(mpc),
    .i_cmp_quals_ok(qok), .o_break_req(immediate_break), .o_armed(armed), .o_tracing(tracing));
  dtbb_cpu_model dtbb_cpu_model_i (.i_core_clk, .i_run(run), .i_load(load), .i_start_pc(spc),
    .i_stride(step), .o_head_valid(hv), .o_head_pc(hpc));

  task automatic summarize();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic w);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_word <= w;
    i_reg_wr <= 1'h1;
    @(posedge i_core_clk);
    i_reg_wr <= 1'h0;
    @(posedge i_core_clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic w, input logic [15:0] e);
    i_reg_addr <= a;
    i_reg_word <= w;
    i_reg_rd <= 1'h1;
    @(posedge i_core_clk);
    i_reg_rd <= 1'h0;
    #1 chk(rdata, e);
    @(posedge i_core_clk);
  endtask

  // Reference compression of executed addresses into rows
  task automatic put(input logic [17:0] pc);
    int k;
    k = rows.size();
    if (k == 0 || pc[17:6] != base[17:6]
        || (rows[k-1][19:18] inside {2'h0, 2'h3} && tot % 64 == 0)) begin
      rows.push_back({2'h0, pc});
      base = pc;
    end else if (rows[k-1][19:18] == 2'h1) begin
      rows[k-1] = {2'h2, 6'h00, pc[5:0], rows[k-1][5:0]};
    end else if (rows[k-1][19:18] == 2'h2) begin
      rows[k-1] = {2'h3, pc[5:0], rows[k-1][11:0]};
    end else begin
      rows.push_back({2'h1, 12'h000, pc[5:0]});
    end
    if (rows.size() > k) begin
      tot++;
    end
    if (rows.size() > 64) begin
      void'(rows.pop_front());
      wrapped = 1'h1;
    end
  endtask

  task automatic sess(input logic [17:0] st, input logic [15:0] ctl, input int len);
    rows.delete();
    wrapped = 1'h0;
    tot = 0;
    spc <= 18'($random(seed));
    step <= st;
    load <= 1'h1;
    @(posedge i_core_clk);
    load <= 1'h0;
    wr(A_CT, ctl, 1'h1);
    rc(A_HI, 1'h1, 16'h0000);
    #1 chk(tracing, 1'h1);
    run <= 1'h1;
    repeat (len) @(posedge i_core_clk);
    run <= 1'h0;
    @(posedge i_core_clk);
  endtask

  task automatic opn();
    wr(A_CT, 16'h0020, 1'h1);
    rc(A_HI, 1'h1, 16'h0000);
    wr(A_HI, 16'h0000, 1'h1);
  endtask

  task automatic dump();
    rc(A_CN, 1'h1, {8'h00, wrapped, 7'(rows.size())});
    foreach (rows[i]) begin
      rc(A_HI, 1'h1, rows[i][15:0]);
      rc(A_HI, 1'h1, {12'h000, rows[i][19:16]});
    end
  endtask

  initial begin
    forever #50 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
    if (tracing === 1'h1 && hv === 1'h1) begin
      put(hpc);
    end
  end

  initial begin
    repeat (6) @(posedge i_core_clk);
    i_sys_rst <= 1'h0;
    @(posedge i_core_clk);
    wr(A_TG, 16'h0000, 1'h1);
    sess(18'h00002, 16'h0031, 40);
    cm <= 3'h1;
    qok <= 3'h1;
    @(posedge i_core_clk);
    cm <= 3'h0;
    #1 chk(immediate_break, 1'h1);
    chk(armed, 1'h0);
    @(posedge i_core_clk);
    opn();
    rc(A_HI, 1'h0, 16'h0000);
    rc(A_LO, 1'h1, 16'h0000);
    i_secured <= 1'h1;
    rc(A_HI, 1'h1, 16'h0000);
    i_secured <= 1'h0;
    dump();
    wr(A_HI, 16'h0000, 1'h0);
    rc(A_HI, 1'h1, rows[0][15:0]);
    sess(18'h00040, 16'h0021, 70);
    i_sys_rst <= 1'h1;
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'h0;
    @(posedge i_core_clk);
    opn();
    dump();
    wr(A_TG, 16'h0002, 1'h1);
    p = 18'($random(seed)) & 18'h3FFFE;
    spc <= p - 18'h00008;
    step <= 18'h00002;
    load <= 1'h1;
    @(posedge i_core_clk);
    load <= 1'h0;
    wr(A_CT, 16'h0011, 1'h1);
    mpc <= p;
    cm <= 3'h2;
    qok <= 3'h0;
    @(posedge i_core_clk);
    cm <= 3'h0;
    run <= 1'h1;
    seen = 1'h0;
    for (n = 0; n < 20 && !seen; n++) begin
      #1 q = hpc;
      @(posedge i_core_clk);
      #1 seen = (immediate_break === 1'h1);
    end
    chk(seen, 1'h1);
    chk(q, p);
    @(posedge i_core_clk);
    wr(A_TG, 16'h0000, 1'h1);
    step <= 18'h00040;
    for (int i = 0; i < 8; i++) begin
      wr(A_CT, 16'h0023 | 16'(i << 2), 1'h1);
      n = 0;
      #1 seen = (immediate_break === 1'h1);
      while (armed === 1'h1 && n < 200) begin
        @(posedge i_core_clk);
        #1 seen = seen | (immediate_break === 1'h1);
        n++;
      end
      chk(seen, i[2]);
      chk(n > 60, i[0] && !i[1]);
      chk(armed, 1'h0);
      @(posedge i_core_clk);
    end
    run <= 1'h0;
    summarize();
  end
endmodule
`default_nettype wire
